// ### tb/tb_top.sv
// Purpose: Self-checking bench for the flash control register block.
// Assumes: Register offsets are word indices; byte address is four times.
// Notes: A bench model of every register is compared at each access.
`timescale 1ns/1ps
`include "flash_pe_params.svh"
module tb_top;
  import flash_pe_pkg::*;
  logic mclk = 0, nrst = 0, ce = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  seq_status_type seq_status = '0;
  ctrl_type ctrl;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  logic [1:0] m_guard = 2'h2, m_entry = 2'h0;
  logic [7:0] m_pclk = 8'h30;
  logic m_cancel = 0, m_rst = 0;
  logic [4:0] m_irq = 5'h00, m_mask = 5'h00;
  logic [29:0] ti [0:12];
  logic [31:0] td [0:12];
  logic [3:0] ts [0:12];

  flash_pe_control_regs flash_pe_control_regs_i (.mclk(mclk), .nrst(nrst),
    .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seq_status(seq_status), .ctrl(ctrl), .irq(irq));

  always #10 mclk = ~mclk;

  // Cuts a hung handshake short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic rdy_of(input seq_status_type s);
    return !(s.pe_busy | s.cancel_busy | s.lockread_busy | s.blank_busy);
  endfunction

  function automatic logic [1:0] m_resp(input logic [29:0] i);
    return (i inside {`IDX_GUARD, `IDX_STATUS0, `IDX_STATUS1, `IDX_PROTECT,
      `IDX_PCLK, `IDX_RESET, `IDX_ENTRY, `IDX_IRQ_STATUS, `IDX_IRQ_MASK}) ?
      `RESP_OKAY : `RESP_DECERR;
  endfunction

  function automatic logic [31:0] m_read(input logic [29:0] i);
    seq_status_type s;
    s = seq_status;
    case (i)
      `IDX_GUARD: return {30'h0, m_guard};
      `IDX_STATUS0: return {24'h0, rdy_of(s), s.illegal_op, s.erase_fail,
        s.program_fail, 4'h0};
      `IDX_STATUS1: return {24'h0, s.fault, 7'h00};
      `IDX_PROTECT: return {31'h0, m_cancel};
      `IDX_PCLK: return {24'h0, m_pclk};
      `IDX_RESET: return {31'h0, m_rst};
      `IDX_ENTRY: return {24'h0, m_entry[1], 6'h00, m_entry[0]};
      `IDX_IRQ_STATUS: return {27'h0, m_irq};
      `IDX_IRQ_MASK: return {27'h0, m_mask};
      default: return 32'h0;
    endcase
  endfunction

  // Keyed fields change only on a halfword write carrying the right key.
  task automatic m_write(input logic [29:0] i, input logic [31:0] d,
                         input logic [3:0] s);
    logic h;
    h = (s == `STRB_HALF);
    case (i)
      `IDX_GUARD: if (s[0]) m_guard = d[1:0];
      `IDX_PCLK: if (s[0]) m_pclk = d[7:0];
      `IDX_PROTECT: if (h && d[15:8] == `KEY_PROTECT && m_entry != 0)
        m_cancel = d[0];
      `IDX_RESET: if (h && d[15:8] == `KEY_RESET) m_rst = d[0];
      `IDX_ENTRY: if (h && d[15:8] == `KEY_ENTRY) m_entry = {d[7], d[0]};
      `IDX_IRQ_STATUS: if (s[0]) m_irq = m_irq & ~d[4:0];
      `IDX_IRQ_MASK: if (s[0]) m_mask = d[4:0];
      default: ;
    endcase
  endtask

  task automatic chk_out();
    chk("ctrl", {19'h0, ctrl},
      {19'h0, m_rst, m_cancel, m_entry[0], m_entry[1],
      m_guard == `PERMIT_ON, m_pclk});
    chk("irq", {31'h0, irq}, {31'h0, |(m_irq & m_mask)});
  endtask

  task automatic wr(input logic [29:0] i, input logic [31:0] d,
                    input logic [3:0] s);
    logic ta, tw, da, dw;
    logic [1:0] r;
    da = 0;
    dw = 0;
    awaddr <= {i, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(da && dw)) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta) begin
        awvalid <= 0;
        da = 1;
      end
      if (tw) begin
        wvalid <= 0;
        dw = 1;
      end
    end
    do begin
      @(negedge mclk);
      ta = bvalid;
      r = bresp;
      @(posedge mclk);
    end while (!ta);
    bready <= 0;
    @(posedge mclk);
    m_write(i, d, s);
    chk("bresp", {30'h0, r}, {30'h0, m_resp(i)});
    chk_out();
  endtask

  task automatic rd(input logic [29:0] i);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge mclk);
      t = arvalid && arready;
      @(posedge mclk);
    end while (!t);
    arvalid <= 0;
    do begin
      @(negedge mclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end while (!t);
    rready <= 0;
    @(posedge mclk);
    chk("rdata", d, m_read(i));
    chk("rresp", {30'h0, r}, {30'h0, m_resp(i)});
  endtask

  // Interrupt status bits latch rising edges of the reported flags.
  task automatic set_st(input seq_status_type v);
    logic [4:0] o, n;
    o = {rdy_of(seq_status), seq_status.fault, seq_status.illegal_op,
      seq_status.erase_fail, seq_status.program_fail};
    n = {rdy_of(v), v.fault, v.illegal_op, v.erase_fail, v.program_fail};
    seq_status <= v;
    repeat (3) @(posedge mclk);
    m_irq = m_irq | (n & ~o);
    chk_out();
  endtask

  initial begin
    ti = '{`IDX_PROTECT, `IDX_ENTRY, `IDX_ENTRY, `IDX_ENTRY, `IDX_PROTECT,
      `IDX_PROTECT, `IDX_RESET, `IDX_RESET, `IDX_RESET, `IDX_ENTRY,
      `IDX_ENTRY, `IDX_PROTECT, `IDX_RESET};
    td = '{32'h5501, 32'hab81, 32'haa81, 32'haa81, 32'h5401, 32'h5501,
      32'hcc01, 32'hcd00, 32'hcc01, 32'haa01, 32'haa00, 32'h5500, 32'hcc00};
    ts = '{4'h3, 4'h3, 4'hf, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h3,
      4'h3, 4'h3, 4'h3};
    void'($urandom(48373));
    repeat (3) @(posedge mclk);
    nrst <= 1;
    @(posedge mclk);
    chk_out();
    foreach (ti[k]) rd(ti[k]);
    rd(`IDX_GUARD);
    rd(`IDX_PCLK);
    rd(30'h007fffc8);
    rd(`IDX_IRQ_STATUS);
    $display("test reset_values done");
    wr(`IDX_IRQ_STATUS, 32'h1f, 4'hf);
    repeat (12) begin
      set_st(seq_status_type'(8'($urandom)));
      rd(`IDX_STATUS0);
      rd(`IDX_STATUS1);
      rd(`IDX_IRQ_STATUS);
    end
    wr(`IDX_STATUS0, 32'hff, 4'hf);
    rd(`IDX_STATUS0);
    $display("test status_flags done");
    foreach (ti[k]) begin
      wr(ti[k], td[k], ts[k]);
      rd(ti[k]);
    end
    foreach (ts[k]) wr(`IDX_GUARD, {30'h0, k[1:0]}, 4'h1);
    wr(`IDX_GUARD, 32'h1, 4'h1);
    wr(`IDX_PCLK, $urandom & 32'hff, 4'h3);
    rd(`IDX_PCLK);
    wr(30'h007fffc8, 32'h1, 4'hf);
    $display("test keyed_writes done");
    set_st('0);
    wr(`IDX_IRQ_STATUS, 32'h1f, 4'hf);
    wr(`IDX_IRQ_MASK, 32'h01, 4'hf);
    set_st(8'h08);
    wr(`IDX_IRQ_STATUS, 32'h01, 4'hf);
    set_st(8'h04);
    rd(`IDX_IRQ_STATUS);
    wr(`IDX_IRQ_MASK, 32'h1e, 4'hf);
    set_st(8'h80);
    set_st(8'h03);
    rd(`IDX_IRQ_STATUS);
    // A failure pulse while the clock enable is low must go unseen.
    ce <= 1'b0;
    seq_status <= 8'h0b;
    @(posedge mclk);
    seq_status <= 8'h03;
    @(posedge mclk);
    ce <= 1'b1;
    set_st(8'h03);
    rd(`IDX_IRQ_STATUS);
    wr(`IDX_IRQ_STATUS, 32'h1f, 4'hf);
    rd(`IDX_IRQ_MASK);
    $display("test interrupts done");
    finish_test();
  end
endmodule // tb_top

// ### verilog/flash_pe_control_regs.sv
// Purpose: Software register set of a code flash sequencer over AXI4-Lite.
// Assumes: Sequencer status inputs are synchronous to mclk.
// Notes: Keyed registers accept only halfword writes to byte lanes 1:0.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "flash_pe_params.svh"

// Overview of operation
// - Status bit 4 shows programming failure.
// - Status bit 5 shows erase failure.
// - Status bit 6 shows illegal command or access.
// - Ready bit 7 low while any operation runs.
// - Ready bit 7 high only when all idle.
// - Second status bit 7 shows sequencer fault.
// - Cancel bit set disables lock-bit protection.
// - Cancel bit needs key 55h, entry nonzero.
// - Key bytes are never stored.
// - Reset bit holds sequencer reset, key CCh.
// - Entry bit 0 selects code read or program/erase.
// - Entry bit 7 requests data program/erase.
// - Entry bits change only with key AAh.
// - Guard field 01 permits, 10 inhibits.
module flash_pe_control_regs (
  input wire logic mclk, // System clock, 50 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire flash_pe_pkg::seq_status_type seq_status, // Sequencer state.
  output flash_pe_pkg::ctrl_type ctrl, // Control toward the sequencer.
  output logic irq // Level interrupt.
);
  import flash_pe_pkg::*;

  wr_state_type wr_state_q;
  rd_state_type rd_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic cancel_q;
  logic seq_reset_q;
  logic code_pe_q;
  logic data_pe_q;
  logic [7:0] pclk_q;
  logic [1:0] guard_q;
  logic [4:0] irq_status_q;
  logic [4:0] irq_mask_q;
  logic [4:0] irq_prev_q;
  logic [4:0] irq_now;
  logic [4:0] irq_event;
  logic wr_exec;
  logic [29:0] wr_idx;
  logic [29:0] rd_idx;
  logic half_word;
  logic [7:0] key;
  logic any_busy;
  logic key_ok_protect;
  logic key_ok_reset;
  logic key_ok_entry;
  logic [7:0] status0;
  logic [7:0] status1;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign any_busy = seq_status.pe_busy | seq_status.cancel_busy |
                    seq_status.lockread_busy | seq_status.blank_busy;

  // Ready is the plain complement of every busy source.
  assign status0 = {~any_busy,
                    seq_status.illegal_op,
                    seq_status.erase_fail,
                    seq_status.program_fail,
                    4'h0};
  assign status1 = {seq_status.fault, 7'h00};

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = (wr_state_q == W_COLLECT) && !aw_got_q;
  assign s_axi_wready = (wr_state_q == W_COLLECT) && !w_got_q;
  assign s_axi_bvalid = (wr_state_q == W_RESP);
  assign s_axi_bresp = bresp_q;
  assign wr_exec = ce && (wr_state_q == W_COLLECT) && aw_got_q && w_got_q;
  assign wr_idx = aw_addr_q[31:2];
  assign half_word = (w_strb_q == `STRB_HALF);
  assign key = w_data_q[15:8];

  assign key_ok_protect = wr_exec && (wr_idx == `IDX_PROTECT) && half_word &&
                          (key == `KEY_PROTECT) &&
                          (code_pe_q | data_pe_q);
  assign key_ok_reset = wr_exec && (wr_idx == `IDX_RESET) && half_word &&
                        (key == `KEY_RESET);
  assign key_ok_entry = wr_exec && (wr_idx == `IDX_ENTRY) && half_word &&
                        (key == `KEY_ENTRY);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_state_q <= W_COLLECT;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end else if (ce) begin
      case (wr_state_q)
        W_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
          end
          if (aw_got_q && w_got_q) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wr_state_q <= W_RESP;
            case (wr_idx)
              `IDX_GUARD, `IDX_STATUS0, `IDX_STATUS1, `IDX_PROTECT,
              `IDX_PCLK, `IDX_RESET, `IDX_ENTRY, `IDX_IRQ_STATUS,
              `IDX_IRQ_MASK: bresp_q <= `RESP_OKAY;
              default: bresp_q <= `RESP_DECERR;
            endcase
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= W_COLLECT;
          end
        end
        default: wr_state_q <= W_COLLECT;
      endcase
    end
  end

  // Only the protected bit is kept; the key byte is a qualifier only.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cancel_q <= `RST_CANCEL;
    end else if (ce && key_ok_protect) begin
      cancel_q <= w_data_q[`BIT_CANCEL];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq_reset_q <= `RST_SEQ_RESET;
    end else if (ce && key_ok_reset) begin
      seq_reset_q <= w_data_q[`BIT_SEQ_RESET];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      code_pe_q <= `RST_CODE_PE;
      data_pe_q <= `RST_DATA_PE;
    end else if (ce && key_ok_entry) begin
      code_pe_q <= w_data_q[`BIT_CODE_PE];
      data_pe_q <= w_data_q[`BIT_DATA_PE];
    end
  end

  // The clock notice holds whatever software loads; no range check.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pclk_q <= `RST_PCLK;
    end else if (ce && wr_exec && (wr_idx == `IDX_PCLK) && w_strb_q[0]) begin
      pclk_q <= w_data_q[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      guard_q <= `RST_GUARD;
    end else if (ce && wr_exec && (wr_idx == `IDX_GUARD) && w_strb_q[0]) begin
      guard_q <= w_data_q[1:0];
    end
  end

  assign ctrl.sequencer_reset_bit = seq_reset_q;
  assign ctrl.lock_protect_cancel_bit = cancel_q;
  assign ctrl.code_pe_entry_bit = code_pe_q;
  assign ctrl.data_pe_entry_bit = data_pe_q;
  // Codes other than 01 also inhibit, so only an exact 01 permits.
  assign ctrl.write_erase_permit = (guard_q == `PERMIT_ON);
  assign ctrl.periph_clock_mhz_field = pclk_q;

  // Interrupt events are rising edges of the failure flags and of ready.
  assign irq_now = {~any_busy, seq_status.fault, seq_status.illegal_op,
                    seq_status.erase_fail, seq_status.program_fail};
  assign irq_event = irq_now & ~irq_prev_q;

  // Ready idles high, so its history starts high to avoid a false event.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_prev_q <= `RST_IRQ_PREV;
    end else if (ce) begin
      irq_prev_q <= irq_now;
    end
  end

  // A new event wins over a simultaneous write-one-to-clear.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_status_q <= `RST_IRQ;
    end else if (ce) begin
      if (wr_exec && (wr_idx == `IDX_IRQ_STATUS) && w_strb_q[0]) begin
        irq_status_q <= (irq_status_q & ~w_data_q[4:0]) | irq_event;
      end else begin
        irq_status_q <= irq_status_q | irq_event;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= `RST_IRQ;
    end else if (ce && wr_exec && (wr_idx == `IDX_IRQ_MASK) && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[4:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // Read channel: one outstanding read, data registered.
  assign s_axi_arready = (rd_state_q == R_IDLE);
  assign s_axi_rvalid = (rd_state_q == R_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_idx = s_axi_araddr[31:2];

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (rd_idx)
      `IDX_GUARD: rd_mux = {30'h00000000, guard_q};
      `IDX_STATUS0: rd_mux = {24'h000000, status0};
      `IDX_STATUS1: rd_mux = {24'h000000, status1};
      `IDX_PROTECT: rd_mux = {31'h00000000, cancel_q};
      `IDX_PCLK: rd_mux = {24'h000000, pclk_q};
      `IDX_RESET: rd_mux = {31'h00000000, seq_reset_q};
      `IDX_ENTRY: rd_mux = {24'h000000, data_pe_q, 6'h00, code_pe_q};
      `IDX_IRQ_STATUS: rd_mux = {27'h0000000, irq_status_q};
      `IDX_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_state_q <= R_IDLE;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (ce) begin
      case (rd_state_q)
        R_IDLE: begin
          if (s_axi_arvalid) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
            rd_state_q <= R_DATA;
          end
        end
        R_DATA: begin
          if (s_axi_rready) begin
            rd_state_q <= R_IDLE;
          end
        end
        default: rd_state_q <= R_IDLE;
      endcase
    end
  end

  // Checks.
  logic ar_fire;
  assign ar_fire = ce && s_axi_arvalid && s_axi_arready;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ready_low_busy: assert property (
    ar_fire && rd_idx == `IDX_STATUS0 && any_busy
    |=> !s_axi_rdata[`BIT_READY])
    else $error("ready read high while busy");

  a_ready_high_idle: assert property (
    ar_fire && rd_idx == `IDX_STATUS0 && !any_busy
    |=> s_axi_rdata[`BIT_READY])
    else $error("ready read low while idle");

  a_prog_fail_read: assert property (
    ar_fire && rd_idx == `IDX_STATUS0
    |=> s_axi_rdata[`BIT_PROG_FAIL] == $past(seq_status.program_fail) &&
        s_axi_rdata[`BIT_ERASE_FAIL] == $past(seq_status.erase_fail))
    else $error("fail flags read wrong");

  a_illegal_read: assert property (
    ar_fire && rd_idx == `IDX_STATUS0
    |=> s_axi_rdata[`BIT_ILLEGAL] == $past(seq_status.illegal_op))
    else $error("illegal flag read wrong");

  a_fault_read: assert property (
    ar_fire && rd_idx == `IDX_STATUS1
    |=> s_axi_rdata == {24'h000000, $past(seq_status.fault), 7'h00})
    else $error("fault flag read wrong");

  a_cancel_keyed: assert property (
    $changed(ctrl.lock_protect_cancel_bit) |-> $past(key_ok_protect))
    else $error("cancel bit changed without key");

  a_reset_keyed: assert property (
    $changed(ctrl.sequencer_reset_bit) |-> $past(key_ok_reset))
    else $error("reset bit changed without key");

  a_entry_keyed: assert property (
    $changed({ctrl.code_pe_entry_bit, ctrl.data_pe_entry_bit})
    |-> $past(key_ok_entry))
    else $error("entry bits changed without key");

  a_entry_follows: assert property (
    key_ok_entry |=> ctrl.code_pe_entry_bit == $past(w_data_q[0]) &&
                     ctrl.data_pe_entry_bit == $past(w_data_q[7]))
    else $error("entry write not applied");

  a_guard_permit: assert property (
    ce && wr_exec && wr_idx == `IDX_GUARD && w_strb_q[0]
    |=> ctrl.write_erase_permit == ($past(w_data_q[1:0]) == 2'h1))
    else $error("permit decode wrong");

  a_width_ignored: assert property (
    wr_exec && wr_idx == `IDX_RESET && !half_word
    |=> $stable(ctrl.sequencer_reset_bit))
    else $error("non halfword write changed reset bit");

  a_event_sticky: assert property (
    ce && |irq_event |=> (irq_status_q & $past(irq_event)) == $past(irq_event))
    else $error("interrupt event not latched");

  a_read_unmapped: assert property (
    ar_fire && !rd_hit
    |=> s_axi_rresp == `RESP_DECERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");

  a_pclk_load: assert property (
    wr_exec && wr_idx == `IDX_PCLK && w_strb_q[0]
    |=> ctrl.periph_clock_mhz_field == $past(w_data_q[7:0]))
    else $error("clock notice write not applied");

  c_entry_write: cover property (key_ok_entry ##1 ctrl.code_pe_entry_bit);
  c_wrong_key: cover property (wr_exec && wr_idx == `IDX_RESET && !key_ok_reset);
  c_cancel_write: cover property (key_ok_protect);
  c_irq_raise: cover property (!irq ##1 irq);
  c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);

endmodule // flash_pe_control_regs

// ### verilog/flash_pe_params.svh
// Purpose: Register indices, field positions, keys and reset values.
// Assumes: AXI4-Lite byte address equals four times a register index.
// Notes: Index values are 30 bits and compare with address bits 31:2.
`ifndef FLASH_PE_PARAMS_SVH
`define FLASH_PE_PARAMS_SVH

`define IDX_GUARD 30'h0008c289
`define IDX_STATUS0 30'h007fffb0
`define IDX_STATUS1 30'h007fffb1
`define IDX_PROTECT 30'h007fffb4
`define IDX_PCLK 30'h007fffe8
`define IDX_RESET 30'h007fffc0
`define IDX_ENTRY 30'h007fffc2
`define IDX_IRQ_STATUS 30'h007fffc4
`define IDX_IRQ_MASK 30'h007fffc5

`define BIT_PROG_FAIL 4
`define BIT_ERASE_FAIL 5
`define BIT_ILLEGAL 6
`define BIT_READY 7
`define BIT_FAULT 7
`define BIT_CANCEL 0
`define BIT_SEQ_RESET 0
`define BIT_CODE_PE 0
`define BIT_DATA_PE 7

`define KEY_PROTECT 8'h55
`define KEY_RESET 8'hcc
`define KEY_ENTRY 8'haa
`define STRB_HALF 4'h3
`define PERMIT_ON 2'h1
`define PERMIT_OFF 2'h2

`define RST_CANCEL 1'h0
`define RST_SEQ_RESET 1'h0
`define RST_CODE_PE 1'h0
`define RST_DATA_PE 1'h0
`define RST_PCLK 8'h30
`define RST_GUARD 2'h2
`define RST_IRQ 5'h00
`define RST_IRQ_PREV 5'h10

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ### verilog/flash_pe_pkg.sv
// Purpose: Types shared by the flash control register block.
// Assumes: Constants live in flash_pe_params.svh.
// Notes: Structs carry the sequencer status and the control outputs.
package flash_pe_pkg;

  typedef struct packed {
    logic pe_busy;
    logic cancel_busy;
    logic lockread_busy;
    logic blank_busy;
    logic program_fail;
    logic erase_fail;
    logic illegal_op;
    logic fault;
  } seq_status_type;

  typedef struct packed {
    logic sequencer_reset_bit;
    logic lock_protect_cancel_bit;
    logic code_pe_entry_bit;
    logic data_pe_entry_bit;
    logic write_erase_permit;
    logic [7:0] periph_clock_mhz_field;
  } ctrl_type;

  typedef enum logic [1:0] {
    W_COLLECT = 2'b01,
    W_RESP = 2'b10
  } wr_state_type;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } rd_state_type;

endpackage
